// ===== src/clock_gate_pkg.sv
// Purpose: Constants for the peripheral clock gating block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Function
// Function
// - Gate bit one delivers peripheral clock
// - Gate bit zero stops peripheral clock
// - Access to unclocked peripheral gives bus fault
// - All gate bits reset to zero
// - Run, sleep, deep-sleep gate registers, same layout
// - Sleep registers apply only with auto gating
// - Deep-sleep register at 0x124, resets zero
// - Bits 18..16 gate timers c, b, a
// - Bits 14, 12 gate two-wire b, a
// - Bits 5, 4 gate sync serial b, a
// - Bits 1, 0 gate async serial b, a
// - Reserved bits read-only zero, software preserves
package clock_gate_pkg;

	// Register byte offsets within the system control block
	localparam logic [11:0] RUN_CONFIG_OFFSET = 12'h060;
	localparam logic [11:0] RUN_GATE_OFFSET = 12'h104;
	localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h114;
	localparam logic [11:0] DEEP_GATE_OFFSET = 12'h124;
	localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h200;
	localparam logic [11:0] IRQ_MASK_OFFSET = 12'h204;
	localparam logic [11:0] MODE_STATUS_OFFSET = 12'h208;

	// Gate register field positions
	localparam int ASYNC_SERIAL_A_BIT = 0;
	localparam int ASYNC_SERIAL_B_BIT = 1;
	localparam int SYNC_SERIAL_A_BIT = 4;
	localparam int SYNC_SERIAL_B_BIT = 5;
	localparam int TWO_WIRE_A_BIT = 12;
	localparam int TWO_WIRE_B_BIT = 14;
	localparam int GP_TIMER_A_BIT = 16;
	localparam int GP_TIMER_B_BIT = 17;
	localparam int GP_TIMER_C_BIT = 18;
	localparam int GP_TIMER_D_BIT = 19;
	localparam int COMPARATOR_A_BIT = 24;
	localparam int COMPARATOR_B_BIT = 25;

	// Writable gate bits; every other position is reserved
	localparam logic [31:0] GATE_WRITABLE_MASK = 32'h030f5033;
	localparam logic [31:0] GATE_RESET = 32'h00000000;

	// Run configuration: automatic clock gating enable
	localparam int AUTO_GATING_BIT = 27;
	localparam logic [31:0] RUN_CONFIG_MASK = 32'h08000000;
	localparam logic [31:0] RUN_CONFIG_RESET = 32'h00000000;

	// Interrupt status and mask layout
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_MODE_BIT = 1;
	localparam logic [31:0] IRQ_MASK_BITS = 32'h00000003;
	localparam logic [31:0] IRQ_RESET = 32'h00000000;

	// Power modes, Gray coded along run, sleep, deep-sleep
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP = 2'b11
	} power_mode_t;

endpackage

// ===== src/deep_sleep_clock_gating.sv
// Purpose: Per-peripheral clock gating with run, sleep and deep-sleep sets
// Assumes: Mode requests and access strobes are synchronous to mclk
// Notes: Enables lag a mode request by two mclk edges; fault answers lag their access by one
`timescale 1ns/1ps
module deep_sleep_clock_gating
	import clock_gate_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int UNIT_W = 5
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor power state requests
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	// Peripheral access check
	input wire logic accessValid,
	input wire logic [UNIT_W-1:0] accessUnit,
	output logic accessGrant,
	output logic accessFault,
	// Clock enables and status
	output logic [31:0] periphClkEn,
	output logic [1:0] powerMode,
	output logic irq
);

	// Masked write merge shared by all gate registers
	function automatic logic [31:0] mergeWrite(input logic [31:0] wdata, input logic [31:0] mask);
		mergeWrite = wdata & mask;
	endfunction

	// Address decode used for read and write paths
	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		isMapped = (addr == RUN_CONFIG_OFFSET) || (addr == RUN_GATE_OFFSET) ||
			(addr == SLEEP_GATE_OFFSET) || (addr == DEEP_GATE_OFFSET) ||
			(addr == IRQ_STATUS_OFFSET) || (addr == IRQ_MASK_OFFSET) ||
			(addr == MODE_STATUS_OFFSET);
	endfunction

	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] runConfig_q;
	logic [31:0] runGate_q;
	logic [31:0] sleepGate_q;
	logic [31:0] deepGate_q;
	logic [31:0] irqStatus_q;
	logic [31:0] irqMask_q;
	logic [31:0] clkEn_q;
	logic [31:0] gateSel_d;
	logic grant_q;
	logic fault_q;
	logic irq_q;
	logic faultEvent;
	logic modeEvent;
	logic commit;
	logic wrCommit;
	logic rdCommit;
	logic [31:0] readMux;
	power_mode_t mode_q;
	power_mode_t mode_d;

	// Transfer completes at the edge where pready is seen high
	assign commit = psel && penable && pready_q;
	assign wrCommit = commit && pwrite && !pslverr_q;
	assign rdCommit = commit && !pwrite && !pslverr_q;

	// Read data selection; reserved bits are zero in every source
	always_comb
	begin
		readMux = 32'h00000000;
		unique case (paddr)
			RUN_CONFIG_OFFSET: readMux = runConfig_q;
			RUN_GATE_OFFSET: readMux = runGate_q;
			SLEEP_GATE_OFFSET: readMux = sleepGate_q;
			DEEP_GATE_OFFSET: readMux = deepGate_q;
			IRQ_STATUS_OFFSET: readMux = irqStatus_q;
			IRQ_MASK_OFFSET: readMux = irqMask_q;
			MODE_STATUS_OFFSET: readMux = {30'h00000000, mode_q};
			default: readMux = 32'h00000000;
		endcase
	end

	// APB handshake: one wait state so read data comes from a flop
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= !isMapped(paddr);
			prdata_q <= (pwrite || !isMapped(paddr)) ? 32'h00000000 : readMux;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
	end

	// Run configuration holds only the automatic gating enable
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			runConfig_q <= RUN_CONFIG_RESET;
		else if (wrCommit && paddr == RUN_CONFIG_OFFSET)
			runConfig_q <= mergeWrite(pwdata, RUN_CONFIG_MASK);
	end

	// Three gate sets of identical layout; reserved bits never store
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			runGate_q <= GATE_RESET;
			sleepGate_q <= GATE_RESET;
			deepGate_q <= GATE_RESET;
		end
		else if (wrCommit)
		begin
			if (paddr == RUN_GATE_OFFSET)
				runGate_q <= mergeWrite(pwdata, GATE_WRITABLE_MASK);
			if (paddr == SLEEP_GATE_OFFSET)
				sleepGate_q <= mergeWrite(pwdata, GATE_WRITABLE_MASK);
			if (paddr == DEEP_GATE_OFFSET)
				deepGate_q <= mergeWrite(pwdata, GATE_WRITABLE_MASK);
		end
	end

	// Power mode follows the processor request, deep-sleep has priority
	always_comb
	begin
		if (deepSleepReq)
			mode_d = MODE_DEEP;
		else if (sleepReq)
			mode_d = MODE_SLEEP;
		else
			mode_d = MODE_RUN;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			mode_q <= MODE_RUN;
		else
			mode_q <= mode_d;
	end

	assign modeEvent = (mode_d != mode_q);

	// Without automatic gating the run set stays in force in every mode
	always_comb
	begin
		gateSel_d = runGate_q;
		if (runConfig_q[AUTO_GATING_BIT])
		begin
			unique case (mode_q)
				MODE_RUN: gateSel_d = runGate_q;
				MODE_SLEEP: gateSel_d = sleepGate_q;
				MODE_DEEP: gateSel_d = deepGate_q;
				default: gateSel_d = runGate_q;
			endcase
		end
	end

	// Enable per peripheral; a zero bit stops that clock
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			clkEn_q <= GATE_RESET;
		else
			clkEn_q <= gateSel_d & GATE_WRITABLE_MASK;
	end

	// Access check against the enable that is in force right now
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			grant_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			grant_q <= accessValid && clkEn_q[accessUnit];
			fault_q <= accessValid && !clkEn_q[accessUnit];
		end
	end

	assign faultEvent = accessValid && !clkEn_q[accessUnit];

	// Sticky status; a new event wins over the clear by read
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			irqStatus_q <= IRQ_RESET;
		else
		begin
			if (rdCommit && paddr == IRQ_STATUS_OFFSET)
				irqStatus_q <= IRQ_RESET;
			if (faultEvent)
				irqStatus_q[IRQ_FAULT_BIT] <= 1'b1;
			if (modeEvent)
				irqStatus_q[IRQ_MODE_BIT] <= 1'b1;
		end
	end

	// Interrupt mask, same layout as status
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			irqMask_q <= IRQ_RESET;
		else if (wrCommit && paddr == IRQ_MASK_OFFSET)
			irqMask_q <= mergeWrite(pwdata, IRQ_MASK_BITS);
	end

	// Level interrupt; lags status by one edge to stay a flop output
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(irqStatus_q & irqMask_q);
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign accessGrant = grant_q;
	assign accessFault = fault_q;
	assign periphClkEn = clkEn_q;
	assign powerMode = mode_q;
	assign irq = irq_q;

endmodule

// ===== tb/deep_sleep_clock_gating_checker.sv
// Purpose: Port assertions for the gating block
// Assumes: Bound to each block instance
// Notes: Answers lag their cause by one edge
`timescale 1ns/1ps
module deep_sleep_clock_gating_checker
	import clock_gate_pkg::*;
#(
	parameter int UNIT_W = 5
)
(
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Modes and access
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	input wire logic accessValid,
	input wire logic [UNIT_W-1:0] accessUnit,
	input wire logic accessGrant,
	input wire logic accessFault,
	input wire logic [31:0] periphClkEn,
	input wire logic [1:0] powerMode
);
	// One domain, so clock and reset are shared
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// Setup cycle, then the first access cycle
	sequence setupS;
		psel && !penable;
	endsequence
	sequence accessS;
		setupS ##1 psel && penable;
	endsequence
	ready_time_a: assert property (accessS |=> pready) else $error("late ready");
	error_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data");
	reserved_off_a: assert property ((periphClkEn & ~GATE_WRITABLE_MASK) == 32'h0)
		else $error("reserved on");
	grant_on_a: assert property (accessValid && periphClkEn[accessUnit] |=> accessGrant && !accessFault)
		else $error("no grant");
	fault_off_a: assert property (accessValid && !periphClkEn[accessUnit] |=> accessFault && !accessGrant)
		else $error("no fault");
	deep_mode_a: assert property (deepSleepReq |=> powerMode == MODE_DEEP) else $error("not deep");
	run_mode_a: assert property (!sleepReq && !deepSleepReq |=> powerMode == MODE_RUN) else $error("not run");
	// Reset must clear enables even while held
	reset_zero_a: assert property (disable iff (1'b0) !reset_n |=> periphClkEn == 32'h0)
		else $error("enable in reset");
endmodule
bind deep_sleep_clock_gating deep_sleep_clock_gating_checker #(.UNIT_W(UNIT_W)) chk (.mclk(mclk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq),
	.deepSleepReq(deepSleepReq), .accessValid(accessValid), .accessUnit(accessUnit), .accessGrant(accessGrant),
	.accessFault(accessFault), .periphClkEn(periphClkEn), .powerMode(powerMode));

// ===== tb/deep_sleep_clock_gating_tb_top.sv
// Purpose: Self-checking bench for the gating block
// Assumes: Bus answer waited for, never counted
// Notes: Model holds run, sleep and deep gate sets
`timescale 1ns/1ps
module deep_sleep_clock_gating_tb_top;
	import clock_gate_pkg::*;
	logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, sleepReq = 0, deepSleepReq = 0;
	logic accessValid = 0, pready, pslverr, accessGrant, accessFault, irq, err, auto = 0;
	logic [4:0] accessUnit = 5'h00;
	logic [11:0] paddr = 12'h000;
	logic [11:0] adr [4] = '{RUN_CONFIG_OFFSET, RUN_GATE_OFFSET, SLEEP_GATE_OFFSET, DEEP_GATE_OFFSET};
	logic [31:0] pwdata = 32'h0, prdata, periphClkEn, rd, d, e, lf = 32'h17, gate [3];
	logic [1:0] powerMode;
	int fail_count = 0, samples_checked = 0;
	always #50 mclk = ~mclk;
	deep_sleep_clock_gating dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq),
		.deepSleepReq(deepSleepReq), .accessValid(accessValid), .accessUnit(accessUnit), .accessGrant(accessGrant),
		.accessFault(accessFault), .periphClkEn(periphClkEn), .powerMode(powerMode), .irq(irq));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1;
		// Answer and read data are taken at the rising edge that sees pready high
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic acc(input int u, input logic on);
		@(posedge mclk);
		accessValid <= 1;
		accessUnit <= u[4:0];
		@(posedge mclk);
		accessValid <= 0;
		@(negedge mclk);
		chk({30'h0, accessFault, accessGrant}, on ? 32'h1 : 32'h2);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		reset_n <= 1;
		for (int i = 0; i < 4; i++)
		begin
			apb(0, adr[i], 0);
			chk(rd, 32'h0);
		end
		// Random sets, deep set all ones to expose reserved bits
		for (int i = 1; i < 4; i++)
		begin
			lf = nxt(lf);
			d = (i == 3) ? 32'hffffffff : lf;
			gate[i-1] = d & GATE_WRITABLE_MASK;
			apb(1, adr[i], d);
			apb(0, adr[i], 0);
			chk(rd, gate[i-1]);
		end
		// Without auto gating only the run set may apply; with it, each mode applies its own set
		for (int m = 0; m < 6; m++)
		begin
			if (m == 3)
				apb(1, RUN_CONFIG_OFFSET, RUN_CONFIG_MASK);
			@(posedge mclk);
			sleepReq <= (m % 3 == 1);
			deepSleepReq <= (m % 3 == 2);
			repeat (3) @(negedge mclk);
			e = (m < 3) ? gate[0] : gate[m % 3];
			chk(periphClkEn, e);
			chk({30'h0, powerMode}, {30'h0, (m % 3 == 2) ? MODE_DEEP : (m % 3 == 1) ? MODE_SLEEP : MODE_RUN});
			for (int u = 0; u < 32; u++)
				acc(u, e[u]);
		end
		apb(0, MODE_STATUS_OFFSET, 0);
		chk(rd, {30'h0, MODE_DEEP});
		apb(0, IRQ_STATUS_OFFSET, 0);
		apb(1, IRQ_MASK_OFFSET, 32'h1);
		acc(2, 0);
		repeat (3) @(negedge mclk);
		chk({31'h0, irq}, 32'h1);
		apb(0, IRQ_STATUS_OFFSET, 0);
		chk(rd, 32'h1);
		repeat (2) @(negedge mclk);
		chk({31'h0, irq}, 32'h0);
		apb(1, IRQ_MASK_OFFSET, 32'h0);
		acc(2, 0);
		repeat (3) @(negedge mclk);
		chk({31'h0, irq}, 32'h0);
		apb(0, 12'h0ff, 0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		wrap_up();
	end
	// Cut a hang short far past the expected run
	initial
	begin
		#1000000;
		fail_count++;
		wrap_up();
	end
endmodule
